//--- hw/battery_smi_pkg.sv
package battery_smi_pkg;

    // Register indexes
    localparam logic [7:0] SOURCE_STATUS_IDX     = 8'h43;
    localparam logic [7:0] MISC_SIX_IDX          = 8'h70;
    localparam logic [7:0] BATTERY_CONTROL_IDX   = 8'h74;
    localparam logic [7:0] EVENT_ENABLE_IDX      = 8'h82;
    localparam logic [7:0] PMU_REQUEST_CLEAR_IDX = 8'hA2;
    localparam logic [7:0] CPU_LEVEL_STATUS_IDX  = 8'hA3;
    localparam logic [7:0] EVENT_CONTROL_IDX     = 8'hA5;
    localparam logic [7:0] PMU_CONTROL_TWO_IDX   = 8'hAF;
    localparam logic [7:0] FUNCTION_ENABLE_IDX   = 8'hB0;
    localparam logic [7:0] MISC_PIN_STATUS_IDX   = 8'hB3;

    // Reset values of the writable registers
    localparam logic [7:0] BATTERY_CONTROL_RST = 8'h00;
    localparam logic [7:0] EVENT_ENABLE_RST    = 8'h00;
    localparam logic [7:0] PMU_CONTROL_TWO_RST = 8'h00;
    localparam logic [7:0] FUNCTION_ENABLE_RST = 8'h00;
    localparam logic [7:0] MISC_SIX_RST        = 8'h00;

    // Field positions
    localparam int EXT_ENABLE_BIT      = 4;
    localparam int EXT_POLARITY_BIT    = 5;
    localparam int EXT_LEVEL_BIT       = 1;
    localparam int SOFT_MAINS_BIT      = 5;
    localparam int SLOW_CLOCK_BIT      = 5;
    localparam int FIRST_ENABLE_BIT    = 5;
    localparam int SECOND_ENABLE_BIT   = 6;
    localparam int THIRD_ENABLE_BIT    = 7;
    localparam int LOW_DOZE_EVENT_BIT  = 1;
    localparam int DOZE_SLEEP_EVENT_BIT = 2;
    localparam int SLEEP_SUSP_EVENT_BIT = 3;
    localparam int AUTO_SLEEP_OFF_BIT  = 6;
    localparam int AUTO_SUSP_OFF_BIT   = 7;
    localparam int PMU_STATUS_BIT      = 5;
    localparam int EXT_STATUS_BIT      = 6;
    localparam int MODE_FIELD_LSB      = 4;

    // Synchronised pin positions
    localparam int PIN_FIRST  = 0;
    localparam int PIN_SECOND = 1;
    localparam int PIN_THIRD  = 2;
    localparam int PIN_FINAL  = 3;
    localparam int PIN_MAINS  = 4;
    localparam int PIN_EXT    = 5;
    localparam int PIN_COUNT  = 6;
    localparam logic [PIN_COUNT-1:0] PIN_RST = 6'h2F;

    localparam int IO_SOURCES = 5;

    typedef enum logic [2:0] {
        MODE_HIGH_PLL = 3'h0,
        MODE_LOW_PLL  = 3'h1,
        MODE_DOZE     = 3'h3,
        MODE_SLEEP    = 3'h2,
        MODE_SUSPEND  = 3'h6,
        MODE_OFF      = 3'h7
    } pmu_mode_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_type;

    typedef struct packed {
        logic [PIN_COUNT-1:0] sync1;
        logic [PIN_COUNT-1:0] sync2;
        logic [PIN_COUNT-1:0] sync3;
        logic [PIN_COUNT-1:0] pins;
        logic [7:0]           bat_ctl;
        logic [7:0]           ev_en;
        logic [7:0]           pmu_ctl2;
        logic [7:0]           fn_en;
        logic [7:0]           misc_six;
        logic [IO_SOURCES-1:0] io_stat;
        logic                 io_req;
        logic                 ext_pend;
        logic                 ext_prev;
        logic                 pmu_req;
        logic                 first_flag;
        logic                 first_arm;
        logic                 third_flag;
        logic                 third_arm;
        logic                 second_flag;
        logic                 second_prev;
        logic                 mode_flag;
        logic                 mode_ack;
        logic                 clk_run;
        logic                 stop_pend;
        logic                 active_prev;
        pmu_mode_type         mode;
        logic [7:0]           rdata;
    } state_type;

endpackage

//--- hw/battery_smi_event_logic.sv
// Contract
// - Requests during a handler stay pending and re-raise after it.
// - I/O-decode requests are not re-raised; their status bits read 1.
// - Enable bit 4 enables the external pin; bit 5 picks polarity.
// - Polarity 1 requests while the pin is low, polarity 0 while it is high.
// - External pin level reads at misc pin status bit 1.
// - Requests repeat while the shared pin stays active.
// - Battery inputs warn when low; mains high means external power.
// - First three battery levels read in CPU level status.
// - Control-two bit 5 slows high-speed clock when first warning and mains low.
// - Enable bit 5 arms first warning; after reset 1-to-0 raises.
// - Event control read clears first warning and arms opposite level.
// - First or third event runs clock until refresh after control write.
// - Second warning low, no mains: step down per refresh to Sleep.
// - Stepping resumes after wake-up; enabled mode-change events pause it.
// - Enable bit 6: second warning falling edges request; control read clears.
// - Second warning masked in Sleep, Suspend, Off, final low; Doze starts clock.
// - Enable bit 7: third warning behaves like the first.
// - Final warning never requests and has no readable bit.
// - Final warning low, no mains: step down to Suspend; timers govern Off.
// - Final warning low forces Suspend on the refresh after entering Sleep.
// - Soft mains acts as mains, but only the pin stops forced stepping.
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module battery_smi_event_logic
    import battery_smi_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk_in,
    input  wire logic                  rst_in,
    // Register port
    input  wire reg_req_type           reg_bus_in,
    output logic [7:0]                 reg_rdata_out,
    // Asynchronous pins
    input  wire logic                  external_event_pin_in,
    input  wire logic                  battery_warn_first_n_in,
    input  wire logic                  battery_warn_second_n_in,
    input  wire logic                  battery_warn_third_n_in,
    input  wire logic                  battery_warn_final_n_in,
    input  wire logic                  mains_present_in,
    // Core and PMU context, same clock
    input  wire logic                  handler_active_in,
    input  wire logic                  refresh_tick_in,
    input  wire logic [IO_SOURCES-1:0] io_decode_event_in,
    input  wire logic                  wake_event_in,
    input  wire logic                  suspend_timeout_in,
    // Results
    output logic                       smi_request_out,
    output pmu_mode_type               pmu_mode_out,
    output logic                       cpu_clock_run_out,
    output logic                       cpu_clock_slow_out
);

    state_type state_reg;
    state_type state_next;

    logic       rd_hit;
    logic       wr_hit;
    logic       soft_or_pin_mains;
    logic       ext_active;
    logic       handler_start;
    logic       first_low;
    logic       second_low;
    logic       third_low;
    logic       final_low;
    logic       mains_pin;
    logic       force_sleep;
    logic       force_susp;
    logic       want_step;
    logic       step_event_on;
    logic       first_fire;
    logic       third_fire;
    logic       second_fire;
    logic       ctl_read;
    logic       ctl_write;
    pmu_mode_type mode_down;

    always_comb
    begin
        state_next = state_reg;

        // Three-stage pin capture
        state_next.sync1 = {external_event_pin_in, mains_present_in, battery_warn_final_n_in,
                            battery_warn_third_n_in, battery_warn_second_n_in, battery_warn_first_n_in};
        state_next.sync2 = state_reg.sync1;
        state_next.sync3 = state_reg.sync2;
        for (int i = 0; i < PIN_COUNT; i++)
        begin
            if (state_reg.sync2[i] == state_reg.sync3[i])
            begin
                state_next.pins[i] = state_reg.sync3[i];
            end
        end

        first_low  = ~state_reg.pins[PIN_FIRST];
        second_low = ~state_reg.pins[PIN_SECOND];
        third_low  = ~state_reg.pins[PIN_THIRD];
        final_low  = ~state_reg.pins[PIN_FINAL];
        mains_pin  = state_reg.pins[PIN_MAINS];
        soft_or_pin_mains = mains_pin | state_reg.misc_six[SOFT_MAINS_BIT];

        rd_hit    = reg_bus_in.rd;
        wr_hit    = reg_bus_in.wr;
        ctl_read  = rd_hit && (reg_bus_in.addr == EVENT_CONTROL_IDX);
        ctl_write = wr_hit && (reg_bus_in.addr == EVENT_CONTROL_IDX);

        handler_start = handler_active_in & ~state_reg.active_prev;
        state_next.active_prev = handler_active_in;

        // Register writes
        if (wr_hit)
        begin
            case (reg_bus_in.addr)
                MISC_SIX_IDX:        state_next.misc_six = reg_bus_in.wdata;
                BATTERY_CONTROL_IDX: state_next.bat_ctl  = reg_bus_in.wdata;
                EVENT_ENABLE_IDX:    state_next.ev_en    = reg_bus_in.wdata;
                PMU_CONTROL_TWO_IDX: state_next.pmu_ctl2 = reg_bus_in.wdata;
                FUNCTION_ENABLE_IDX: state_next.fn_en    = reg_bus_in.wdata;
                default:             ;
            endcase
        end

        // Register reads, answered one cycle later
        state_next.rdata = 8'h00;
        if (rd_hit)
        begin
            case (reg_bus_in.addr)
                SOURCE_STATUS_IDX:    state_next.rdata = {1'b0, state_reg.ext_pend, state_reg.pmu_req,
                                                          state_reg.io_stat};
                MISC_SIX_IDX:         state_next.rdata = state_reg.misc_six;
                BATTERY_CONTROL_IDX:  state_next.rdata = state_reg.bat_ctl;
                EVENT_ENABLE_IDX:     state_next.rdata = state_reg.ev_en;
                PMU_REQUEST_CLEAR_IDX: state_next.rdata = {7'h00, state_reg.pmu_req};
                CPU_LEVEL_STATUS_IDX: state_next.rdata = {1'b0, state_reg.mode, 1'b0,
                                                          state_reg.pins[PIN_THIRD:PIN_FIRST]};
                EVENT_CONTROL_IDX:    state_next.rdata = {4'h0, state_reg.mode_flag, state_reg.third_flag,
                                                          state_reg.second_flag, state_reg.first_flag};
                PMU_CONTROL_TWO_IDX:  state_next.rdata = state_reg.pmu_ctl2;
                FUNCTION_ENABLE_IDX:  state_next.rdata = state_reg.fn_en;
                MISC_PIN_STATUS_IDX:  state_next.rdata = {6'h00, state_reg.pins[PIN_EXT], 1'b0};
                default:              state_next.rdata = 8'h00;
            endcase
        end

        // I/O decode sources
        if (rd_hit && (reg_bus_in.addr == SOURCE_STATUS_IDX))
        begin
            state_next.io_stat = '0;
        end
        state_next.io_stat = state_next.io_stat | io_decode_event_in;
        if (handler_start)
        begin
            state_next.io_req = 1'b0;
        end
        if (|io_decode_event_in && !handler_active_in)
        begin
            state_next.io_req = 1'b1;
        end

        // External pin, normalised so that 1 means asserted
        ext_active = state_reg.fn_en[EXT_POLARITY_BIT] ? ~state_reg.pins[PIN_EXT]
                                                       : state_reg.pins[PIN_EXT];
        state_next.ext_prev = ext_active;
        if (handler_start)
        begin
            state_next.ext_pend = 1'b0;
        end
        if (state_reg.fn_en[EXT_ENABLE_BIT] && ext_active)
        begin
            state_next.ext_pend = 1'b1;
        end

        // First warning: level trigger that re-arms on the opposite level
        first_fire = state_reg.ev_en[FIRST_ENABLE_BIT] && !state_reg.first_flag
                     && (first_low == state_reg.first_arm);
        if (ctl_read && state_reg.first_flag)
        begin
            state_next.first_flag = 1'b0;
            state_next.first_arm  = ~state_reg.first_arm;
        end
        if (first_fire)
        begin
            state_next.first_flag = 1'b1;
        end

        // Third warning: same scheme as the first
        third_fire = state_reg.ev_en[THIRD_ENABLE_BIT] && !state_reg.third_flag
                     && (third_low == state_reg.third_arm);
        if (ctl_read && state_reg.third_flag)
        begin
            state_next.third_flag = 1'b0;
            state_next.third_arm  = ~state_reg.third_arm;
        end
        if (third_fire)
        begin
            state_next.third_flag = 1'b1;
        end

        // Second warning: falling edge only
        state_next.second_prev = state_reg.pins[PIN_SECOND];
        second_fire = state_reg.ev_en[SECOND_ENABLE_BIT] && state_reg.second_prev && second_low
                      && !final_low && (state_reg.mode != MODE_SLEEP)
                      && (state_reg.mode != MODE_SUSPEND) && (state_reg.mode != MODE_OFF);
        if (ctl_read)
        begin
            state_next.second_flag = 1'b0;
        end
        if (second_fire)
        begin
            state_next.second_flag = 1'b1;
        end

        // Forced step-down targets
        force_sleep = !state_reg.bat_ctl[AUTO_SLEEP_OFF_BIT] && second_low && !mains_pin;
        force_susp  = (!state_reg.bat_ctl[AUTO_SUSP_OFF_BIT] || state_reg.mode == MODE_SLEEP)
                      && final_low && !mains_pin;

        case (state_reg.mode)
            MODE_HIGH_PLL:
            begin
                mode_down     = MODE_LOW_PLL;
                want_step     = force_sleep || force_susp;
                step_event_on = 1'b0;
            end
            MODE_LOW_PLL:
            begin
                mode_down     = MODE_DOZE;
                want_step     = force_sleep || force_susp;
                step_event_on = state_reg.ev_en[LOW_DOZE_EVENT_BIT];
            end
            MODE_DOZE:
            begin
                mode_down     = MODE_SLEEP;
                want_step     = force_sleep || force_susp;
                step_event_on = state_reg.ev_en[DOZE_SLEEP_EVENT_BIT];
            end
            MODE_SLEEP:
            begin
                mode_down     = MODE_SUSPEND;
                want_step     = force_susp;
                step_event_on = state_reg.ev_en[SLEEP_SUSP_EVENT_BIT];
            end
            MODE_SUSPEND:
            begin
                mode_down     = MODE_OFF;
                want_step     = 1'b0;
                step_event_on = 1'b0;
            end
            default:
            begin
                mode_down     = MODE_OFF;
                want_step     = 1'b0;
                step_event_on = 1'b0;
            end
        endcase

        // A write to event control releases a paused step and clears the mode flag
        if (ctl_write)
        begin
            state_next.mode_flag = 1'b0;
            if (state_reg.mode_flag)
            begin
                state_next.mode_ack = 1'b1;
            end
        end

        if (wake_event_in)
        begin
            state_next.mode     = MODE_HIGH_PLL;
            state_next.mode_ack = 1'b0;
        end
        else if (suspend_timeout_in && state_reg.mode == MODE_SUSPEND)
        begin
            state_next.mode = MODE_OFF;
        end
        else if (refresh_tick_in && want_step)
        begin
            if (step_event_on && !state_reg.mode_ack)
            begin
                state_next.mode_flag = 1'b1;
            end
            else
            begin
                state_next.mode     = mode_down;
                state_next.mode_ack = 1'b0;
            end
        end

        // PMU request
        if (wr_hit && reg_bus_in.addr == PMU_REQUEST_CLEAR_IDX)
        begin
            state_next.pmu_req = 1'b0;
        end
        if ((state_next.first_flag && !state_reg.first_flag)
            || (state_next.second_flag && !state_reg.second_flag)
            || (state_next.third_flag && !state_reg.third_flag)
            || (state_next.mode_flag && !state_reg.mode_flag))
        begin
            state_next.pmu_req = 1'b1;
        end

        // Temporary clock run
        if (ctl_write)
        begin
            state_next.stop_pend = 1'b1;
        end
        if (refresh_tick_in && state_reg.stop_pend)
        begin
            state_next.clk_run   = 1'b0;
            state_next.stop_pend = 1'b0;
        end
        if (first_fire || third_fire || (second_fire && state_reg.mode == MODE_DOZE))
        begin
            state_next.clk_run = 1'b1;
        end

        if (rst_in)
        begin
            state_next             = '0;
            state_next.sync1       = PIN_RST;
            state_next.sync2       = PIN_RST;
            state_next.sync3       = PIN_RST;
            state_next.pins        = PIN_RST;
            state_next.bat_ctl     = BATTERY_CONTROL_RST;
            state_next.ev_en       = EVENT_ENABLE_RST;
            state_next.pmu_ctl2    = PMU_CONTROL_TWO_RST;
            state_next.fn_en       = FUNCTION_ENABLE_RST;
            state_next.misc_six    = MISC_SIX_RST;
            state_next.first_arm   = 1'b1;
            state_next.third_arm   = 1'b1;
            state_next.second_prev = 1'b1;
            state_next.mode        = MODE_HIGH_PLL;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        state_reg <= state_next;
    end

    // Pending sources re-raise as soon as the running handler ends
    assign smi_request_out    = !handler_active_in
                                && (state_reg.pmu_req || state_reg.ext_pend || state_reg.io_req);
    assign reg_rdata_out      = state_reg.rdata;
    assign pmu_mode_out       = state_reg.mode;
    assign cpu_clock_run_out  = state_reg.clk_run;
    assign cpu_clock_slow_out = state_reg.pmu_ctl2[SLOW_CLOCK_BIT] && ~state_reg.pins[PIN_FIRST]
                                && !soft_or_pin_mains && (state_reg.mode == MODE_HIGH_PLL);

endmodule // battery_smi_event_logic

`default_nettype wire

//--- sim/battery_smi_event_logic_sva.sv
`timescale 1ns/10ps
`default_nettype none
module battery_smi_event_logic_sva
    import battery_smi_pkg::*;
(
    // Clock and reset
    input wire logic         ref_clk_in,
    input wire logic         rst_in,
    // Register port
    input wire reg_req_type  reg_bus_in,
    input wire logic [7:0]   reg_rdata_out,
    // Context
    input wire logic         handler_active_in,
    input wire logic         refresh_tick_in,
    input wire logic         wake_event_in,
    input wire logic         suspend_timeout_in,
    // Results
    input wire logic         smi_request_out,
    input wire pmu_mode_type pmu_mode_out,
    input wire logic         cpu_clock_slow_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    AST_HANDLER_MASK: assert property (handler_active_in |-> !smi_request_out)
        else $error("request raised during handler");
    AST_RDATA_IDLE: assert property (!$past(reg_bus_in.rd) |-> reg_rdata_out == 8'h00)
        else $error("read data outside read cycle");
    AST_NO_FINAL_BIT: assert property (reg_bus_in.rd && reg_bus_in.addr == CPU_LEVEL_STATUS_IDX |=> !reg_rdata_out[3])
        else $error("final warning level visible");
    AST_MODE_CAUSE: assert property ($changed(pmu_mode_out)
        |-> $past(refresh_tick_in) || $past(wake_event_in) || $past(suspend_timeout_in))
        else $error("mode changed without tick");
    AST_HIGH_TO_LOW: assert property ($past(pmu_mode_out) == MODE_HIGH_PLL |-> pmu_mode_out inside {MODE_HIGH_PLL, MODE_LOW_PLL})
        else $error("high mode skipped a step");
    AST_DOZE_TO_SLEEP: assert property ($past(pmu_mode_out) == MODE_DOZE
        |-> pmu_mode_out inside {MODE_DOZE, MODE_SLEEP, MODE_HIGH_PLL})
        else $error("doze left in wrong order");
    AST_OFF_BY_TIMEOUT: assert property ($changed(pmu_mode_out) && pmu_mode_out == MODE_OFF
        |-> $past(suspend_timeout_in) && $past(pmu_mode_out) == MODE_SUSPEND)
        else $error("off entered without timeout");
    AST_WAKE_HIGH: assert property (wake_event_in |=> pmu_mode_out == MODE_HIGH_PLL)
        else $error("wake did not reach high mode");
    AST_SLOW_OFF: assert property (reg_bus_in.wr && reg_bus_in.addr == PMU_CONTROL_TWO_IDX
        && !reg_bus_in.wdata[SLOW_CLOCK_BIT] |=> !cpu_clock_slow_out)
        else $error("slow clock kept after disable");
endmodule // battery_smi_event_logic_sva

bind battery_smi_event_logic battery_smi_event_logic_sva u_sva (.ref_clk_in, .rst_in, .reg_bus_in, .reg_rdata_out,
    .handler_active_in, .refresh_tick_in, .wake_event_in, .suspend_timeout_in, .smi_request_out, .pmu_mode_out,
    .cpu_clock_slow_out);
`default_nettype wire

//--- sim/battery_monitor_model.sv
`timescale 1ns/10ps
`default_nettype none
module battery_monitor_model
(
    // Clock
    input  wire logic       ref_clk_in,
    // Commands from the bench
    input  wire logic [3:0] warn_n_in,
    input  wire logic       mains_in,
    input  wire logic       raise_in,
    input  wire logic       ack_in,
    // Pins toward the block
    output logic [3:0]      warn_n_out,
    output logic            mains_out,
    output logic            event_pin_out
);
    logic hold_reg = 1'h0;

    // Hold the line low until acknowledged
    always_ff @(posedge ref_clk_in)
        hold_reg <= raise_in | (hold_reg & !ack_in);

    // Pull-up makes a released line idle high
    assign event_pin_out = hold_reg ? 1'h0 : 1'h1;
    assign warn_n_out    = warn_n_in;
    assign mains_out     = mains_in;
endmodule // battery_monitor_model
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import battery_smi_pkg::*;
;
    localparam logic [7:0] RW_IDX [5] = '{MISC_SIX_IDX, BATTERY_CONTROL_IDX, EVENT_ENABLE_IDX,
                                         PMU_CONTROL_TWO_IDX, FUNCTION_ENABLE_IDX};
    logic         ref_clk = 1'h0;
    logic         rst = 1'h1;
    reg_req_type  bus = '0;
    logic [3:0]   warn = 4'hF;
    logic         mains = 1'h0, raise = 1'h0, hand = 1'h0, tick = 1'h0, wake = 1'h0, tmo = 1'h0;
    logic         ack = 1'h1;
    logic [4:0]   io = 5'h00;
    logic [3:0]   warn_pin;
    logic         mains_pin, ext_pin, smi, run, slow;
    logic [7:0]   rdata, v;
    logic [31:0]  lfsr = 32'h0108;
    pmu_mode_type mode, exp_mode;
    int           fails = 0;
    int           total_checks = 0;

    always #20 ref_clk = ~ref_clk;

    battery_monitor_model monitor (.ref_clk_in(ref_clk), .warn_n_in(warn), .mains_in(mains), .raise_in(raise),
        .ack_in(ack), .warn_n_out(warn_pin), .mains_out(mains_pin), .event_pin_out(ext_pin));

    battery_smi_event_logic DUT (.ref_clk_in(ref_clk), .rst_in(rst), .reg_bus_in(bus), .reg_rdata_out(rdata),
        .external_event_pin_in(ext_pin), .battery_warn_first_n_in(warn_pin[0]),
        .battery_warn_second_n_in(warn_pin[1]), .battery_warn_third_n_in(warn_pin[2]),
        .battery_warn_final_n_in(warn_pin[3]), .mains_present_in(mains_pin), .handler_active_in(hand),
        .refresh_tick_in(tick), .io_decode_event_in(io), .wake_event_in(wake), .suspend_timeout_in(tmo),
        .smi_request_out(smi), .pmu_mode_out(mode), .cpu_clock_run_out(run), .cpu_clock_slow_out(slow));

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic pmu_mode_type next_mode(input pmu_mode_type m, input pmu_mode_type floor_mode);
        if (m == floor_mode)
            return m;
        case (m)
            MODE_HIGH_PLL: return MODE_LOW_PLL;
            MODE_LOW_PLL:  return MODE_DOZE;
            MODE_DOZE:     return MODE_SLEEP;
            MODE_SLEEP:    return floor_mode;
            default:       return m;
        endcase
    endfunction

    task automatic results();
        if (fails == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        cyc(1);
        bus <= '0;
        cyc(1);
    endtask

    task automatic rd(input logic [7:0] a);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
        cyc(1);
        bus <= '0;
        cyc(1);
        v = rdata;
    endtask

    // Let pins settle
    task automatic setw(input logic [3:0] w);
        warn <= w;
        cyc(6);
    endtask

    task automatic step(input pmu_mode_type floor_mode);
        tick <= 1'h1;
        cyc(1);
        tick <= 1'h0;
        cyc(1);
        exp_mode = next_mode(exp_mode, floor_mode);
        check("mode", mode, exp_mode);
    endtask

    task automatic handler(input int n);
        hand <= 1'h1;
        cyc(n);
        hand <= 1'h0;
        cyc(1);
    endtask

    initial
    begin
        cyc(6);
        rst <= 1'h0;
        ack <= 1'h0;
        cyc(1);
        for (int i = 0; i < 5; i++)
        begin
            rd(RW_IDX[i]);
            check("reset value", v, 8'h00);
            lfsr = next_rand(lfsr);
            wr(RW_IDX[i], lfsr[7:0]);
            rd(RW_IDX[i]);
            check("read back", v, lfsr[7:0]);
            wr(RW_IDX[i], 8'h00);
        end
        handler(1);
        wr(PMU_REQUEST_CLEAR_IDX, 8'h00);
        wr(CPU_LEVEL_STATUS_IDX, 8'hFF);
        rd(CPU_LEVEL_STATUS_IDX);
        check("levels", v, {1'h0, MODE_HIGH_PLL, 1'h0, warn[2:0]});
        rd(8'h00);
        check("unmapped", v, 8'h00);
        wr(EVENT_ENABLE_IDX, 8'hE0);
        setw(4'hE);
        check("first request", smi, 1'h1);
        check("clock run", run, 1'h1);
        rd(EVENT_CONTROL_IDX);
        check("first flag", v & 8'h0F, 8'h01);
        wr(PMU_REQUEST_CLEAR_IDX, 8'h00);
        check("request cleared", smi, 1'h0);
        wr(EVENT_CONTROL_IDX, 8'h00);
        check("clock held", run, 1'h1);
        exp_mode = MODE_HIGH_PLL;
        step(MODE_HIGH_PLL);
        check("clock stopped", run, 1'h0);
        setw(4'hF);
        check("opposite level", smi, 1'h1);
        rd(EVENT_CONTROL_IDX);
        wr(PMU_REQUEST_CLEAR_IDX, 8'h00);
        hand <= 1'h1;
        setw(4'hB);
        check("held in handler", smi, 1'h0);
        hand <= 1'h0;
        cyc(1);
        check("pending raised", smi, 1'h1);
        rd(EVENT_CONTROL_IDX);
        check("third flag", v & 8'h0F, 8'h04);
        wr(PMU_REQUEST_CLEAR_IDX, 8'h00);
        wr(PMU_CONTROL_TWO_IDX, 8'h20);
        setw(4'hA);
        check("slow clock", slow, 1'h1);
        wr(MISC_SIX_IDX, 8'h20);
        check("soft mains", slow, 1'h0);
        wr(MISC_SIX_IDX, 8'h00);
        mains <= 1'h1;
        cyc(6);
        check("mains pin", slow, 1'h0);
        mains <= 1'h0;
        wr(EVENT_ENABLE_IDX, 8'h00);
        wr(PMU_CONTROL_TWO_IDX, 8'h00);
        setw(4'hF);
        handler(1);
        wr(PMU_REQUEST_CLEAR_IDX, 8'h00);
        for (int i = 0; i < IO_SOURCES; i++)
        begin
            hand <= 1'h1;
            io <= 5'(1 << i);
            cyc(1);
            io <= 5'h00;
            hand <= 1'h0;
            cyc(2);
            check("io not raised", smi, 1'h0);
            rd(SOURCE_STATUS_IDX);
            check("io status", v & 8'h1F, 8'(1 << i));
        end
        wr(FUNCTION_ENABLE_IDX, 8'h10);
        cyc(1);
        check("rising polarity", smi, 1'h1);
        wr(FUNCTION_ENABLE_IDX, 8'h30);
        handler(1);
        check("idle pin", smi, 1'h0);
        raise <= 1'h1;
        cyc(1);
        raise <= 1'h0;
        cyc(6);
        check("falling edge", smi, 1'h1);
        rd(MISC_PIN_STATUS_IDX);
        check("pin level", v & 8'h02, 8'h00);
        handler(2);
        check("repeated", smi, 1'h1);
        ack <= 1'h1;
        cyc(1);
        ack <= 1'h0;
        cyc(6);
        handler(1);
        check("released", smi, 1'h0);
        wr(FUNCTION_ENABLE_IDX, 8'h00);
        wr(MISC_SIX_IDX, 8'h20);
        setw(4'hD);
        repeat (4) step(MODE_SLEEP);
        wake <= 1'h1;
        cyc(1);
        wake <= 1'h0;
        cyc(1);
        exp_mode = MODE_HIGH_PLL;
        check("wake", mode, exp_mode);
        wr(EVENT_ENABLE_IDX, 8'h02);
        step(MODE_SLEEP);
        exp_mode = MODE_HIGH_PLL;
        step(MODE_SLEEP);
        check("paused", smi, 1'h1);
        wr(EVENT_CONTROL_IDX, 8'h00);
        step(MODE_SLEEP);
        wr(EVENT_ENABLE_IDX, 8'h00);
        wr(PMU_REQUEST_CLEAR_IDX, 8'h00);
        wr(BATTERY_CONTROL_IDX, 8'h80);
        setw(4'h5);
        repeat (3) step(MODE_SUSPEND);
        tmo <= 1'h1;
        cyc(1);
        tmo <= 1'h0;
        cyc(1);
        check("off", mode, MODE_OFF);
        results();
    end

    initial
    begin
        cyc(3000);
        fails++;
        results();
    end
endmodule // tb_top
`default_nettype wire
